// ---- hdl/branch_target_buffer.v ----
// Branch target buffer with two-bit direction counters
`timescale 1ns/1ns
`include "uop_pipeline_defines.vh"
module branch_target_buffer #(
  parameter AW = 16,
  parameter IDX_W = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Prediction lookup
  input wire [AW-1:0] lkPc,
  output wire lkTaken,
  output wire [AW-1:0] lkTarget,
  // Resolved branch update
  input wire updValid,
  input wire [AW-1:0] updPc,
  input wire updTaken,
  input wire [AW-1:0] updTarget,
  output wire updFlip
);
  localparam N = 1 << IDX_W;
  reg [AW-1:0] tag_r [0:N-1];
  reg [AW-1:0] tgt_r [0:N-1];
  reg [1:0] ctr_r [0:N-1];
  reg [N-1:0] val_r;
  reg [1:0] ctr_nxt;
  wire [IDX_W-1:0] lkIdx = lkPc[IDX_W-1:0];
  wire [IDX_W-1:0] upIdx = updPc[IDX_W-1:0];
  wire upHit = val_r[upIdx] && tag_r[upIdx] == updPc;
  wire [1:0] upCtr = upHit ? ctr_r[upIdx] : `CTR_RESET;

  assign lkTaken = val_r[lkIdx] && tag_r[lkIdx] == lkPc && ctr_r[lkIdx][1];
  assign lkTarget = tgt_r[lkIdx];
  // Predicted direction changed by this update
  assign updFlip = updValid && (ctr_nxt[1] != upCtr[1]);

  always @* begin
    ctr_nxt = upCtr;
    if (updTaken && upCtr != 2'h3)
      ctr_nxt = upCtr + 2'h1;
    else if (!updTaken && upCtr != 2'h0)
      ctr_nxt = upCtr - 2'h1;
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      val_r <= {N{1'b0}};
    end else if (updValid) begin
      val_r[upIdx] <= 1'b1;
      tag_r[upIdx] <= updPc;
      ctr_r[upIdx] <= ctr_nxt;
      if (updTaken)
        tgt_r[upIdx] <= updTarget;
    end
  end
endmodule // branch_target_buffer

// ---- hdl/uop_pipeline_defines.vh ----
// Constants for the micro-op pipeline control block
`ifndef UOP_PIPELINE_DEFINES_VH
`define UOP_PIPELINE_DEFINES_VH
// Micro-op classes
`define CLS_ALU 2'h0
`define CLS_FP 2'h1
`define CLS_BR 2'h2
`define CLS_CPLX 2'h3
// Instruction word fields; a micro-op word keeps bits 10:0 in place, except that a complex class becomes ALU
`define INS_WIDTH 16
`define INS_CLS 1:0
`define INS_DST 4:2
`define INS_SRCA 7:5
`define INS_SRCB 10:8
`define INS_IMM 15:11
// Bandwidth figures
`define FE_WIDTH 2
`define DISP_MAX 6
`define ALU_UNITS 2
`define ALU_PER_UNIT 2
`define FP_GAP 2
`define RET_MAX 3
`define TRACE_LEN 4
// Direction counter value for a fresh entry (weakly not taken)
`define CTR_RESET 2'h1
`endif

// ---- hdl/uop_pipeline_trace_retire.v ----
// Pipeline control: fetch, trace cache, dispatch, retire
`timescale 1ns/1ns
`include "uop_pipeline_defines.vh"
// Functional notes
// - Micro-ops reach the core in program order, up to two per cycle.
// - Complex instructions expand into microcode micro-ops.
// - In a trace, predicted-target micro-ops follow the branch directly.
// - At each fetch start a trace-cache hit replaces memory fetch.
// - Predicted branch targets come from trace cache or the branch target buffer.
// - Predicted direction chooses the path along which traces are built.
// - At most six micro-ops dispatched per cycle.
// - A micro-op dispatches once operands are ready and a unit is free.
// - Independent younger micro-ops pass a stalled one.
// - Units take one per cycle; ALUs two each; floating point every two.
// - Basic integer ops complete in half a cycle, ready next cycle.
// - Results commit to architectural state strictly in program order.
// - Exceptions raised only at retirement, in order, then restart.
// - Up to three completed micro-ops retire per cycle.
// - Reorder buffer holds completed micro-ops and orders exceptions.
// - Retired branches update the branch target buffer.
// - Traces whose branch prediction flipped are purged from trace cache.
module uop_pipeline_trace_retire #(
  parameter AW = 16,
  parameter TAG_W = 4,
  parameter TC_IDX_W = 3,
  parameter BTB_IDX_W = 4,
  parameter [15:0] START_PC = 16'h0000,
  parameter [15:0] EXC_VECTOR = 16'h0100
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Instruction memory fetch
  output reg fetchReq_r,
  output reg [AW-1:0] fetchAddr_r,
  input wire memValid,
  input wire [AW-1:0] memAddr,
  input wire [`INS_WIDTH-1:0] memInstr,
  // Dispatch to execution pipelines
  output reg [`DISP_MAX-1:0] dspValid_r,
  output reg [`DISP_MAX*TAG_W-1:0] dspTag_r,
  output reg [`DISP_MAX*2-1:0] dspCls_r,
  // Completion from floating-point and branch units
  input wire cplValid,
  input wire [TAG_W-1:0] cplTag,
  input wire cplExc,
  input wire cplTaken,
  input wire [AW-1:0] cplTarget,
  // Architectural commit and exceptions
  output reg [`RET_MAX-1:0] retValid_r,
  output reg [`RET_MAX*3-1:0] retDst_r,
  output reg [`RET_MAX*AW-1:0] retPc_r,
  output reg excValid_r,
  output reg [AW-1:0] excPc_r,
  output reg flush_r
);
  localparam ROB_N = 1 << TAG_W;
  localparam TC_N = 1 << TC_IDX_W;
  localparam UW = 11 + 2 * AW;
  localparam [TAG_W:0] ROOM_MAX = ROB_N - `FE_WIDTH;
  localparam [3:0] FE_LOOK = 4'h1;
  localparam [3:0] FE_WAIT = 4'h2;
  localparam [3:0] FE_DEC = 4'h4;
  localparam [3:0] FE_TC = 4'h8;

  function [AW-1:0] uPc(input [UW-1:0] u);
    uPc = u[10+AW:11];
  endfunction
  function [AW-1:0] uNext(input [UW-1:0] u);
    uNext = u[UW-1:11+AW];
  endfunction
  function [AW-1:0] incPc(input [AW-1:0] p);
    incPc = p + {{(AW-1){1'b0}}, 1'b1};
  endfunction
  function [TAG_W-1:0] ahead(input [TAG_W-1:0] b, input integer n);
    ahead = b + n[TAG_W-1:0];
  endfunction

  // Front end and trace cache state
  reg [3:0] feState_r;
  reg [AW-1:0] pc_r;
  reg [`INS_WIDTH-1:0] ins_r;
  reg [AW-1:0] insPc_r;
  reg [4:0] ucLeft_r;
  reg [UW-1:0] tcUop_r [0:TC_N*`TRACE_LEN-1];
  reg [AW-1:0] tcTag_r [0:TC_N-1];
  reg [AW-1:0] tcNext_r [0:TC_N-1];
  reg [AW-1:0] tcBrPc_r [0:TC_N-1];
  reg [2:0] tcCnt_r [0:TC_N-1];
  reg [TC_N-1:0] tcVal_r;
  reg [TC_N-1:0] tcHasBr_r;
  reg [TC_IDX_W-1:0] tcLine_r;
  reg [2:0] tcPos_r;
  reg [UW-1:0] bld_r [0:`TRACE_LEN-1];
  reg [2:0] bldCnt_r;
  reg [AW-1:0] bldStart_r;
  reg [AW-1:0] bldBrPc_r;
  reg bldHasBr_r;
  // Reorder buffer state
  reg [UW-1:0] robUop_r [0:ROB_N-1];
  reg [AW-1:0] robTgt_r [0:ROB_N-1];
  reg [TAG_W-1:0] tagA_r [0:ROB_N-1];
  reg [TAG_W-1:0] tagB_r [0:ROB_N-1];
  reg [ROB_N-1:0] robV_r, robDone_r, robIss_r, robExc_r, robTaken_r;
  reg [ROB_N-1:0] waitA_r, waitB_r;
  reg [TAG_W-1:0] head_r, tail_r;
  reg [TAG_W:0] count_r;
  reg [TAG_W-1:0] lastW_r [0:7];
  reg [7:0] lastV_r;
  reg [1:0] fpWait_r;

  wire btbTaken, btbFlip;
  wire [AW-1:0] btbTarget;
  reg btbUpd, btbUpdTaken;
  reg [AW-1:0] btbUpdPc, btbUpdTgt;

  branch_target_buffer #(.AW(AW), .IDX_W(BTB_IDX_W)) u_btb (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .lkPc(insPc_r),
    .lkTaken(btbTaken),
    .lkTarget(btbTarget),
    .updValid(btbUpd),
    .updPc(btbUpdPc),
    .updTaken(btbUpdTaken),
    .updTarget(btbUpdTgt),
    .updFlip(btbFlip)
  );

  wire [TC_IDX_W-1:0] pcIdx = pc_r[TC_IDX_W-1:0];
  wire tcHit = tcVal_r[pcIdx] && tcTag_r[pcIdx] == pc_r;
  wire insBr = ins_r[`INS_CLS] == `CLS_BR;
  wire insCx = ins_r[`INS_CLS] == `CLS_CPLX;
  wire [AW-1:0] insNext = (insBr && btbTaken) ? btbTarget : incPc(insPc_r);
  wire [1:0] decCls = insCx ? `CLS_ALU : ins_r[`INS_CLS];
  wire [UW-1:0] decUop = {insNext, insPc_r, ins_r[10:2], decCls};
  wire room = count_r <= ROOM_MAX;
  wire bldClose = bldCnt_r != 3'h0 &&
    (bldCnt_r == `TRACE_LEN || (insBr && bldHasBr_r) || insCx);

  // Retirement selection
  reg [1:0] rtN;
  reg rtFlush, rtExc, rtGo;
  reg [AW-1:0] rtRedirect, rtExcPc, actNext;
  reg [TAG_W-1:0] ri;
  integer k;
  always @* begin
    rtN = 2'h0;
    rtFlush = 1'b0;
    rtExc = 1'b0;
    rtGo = 1'b1;
    rtRedirect = EXC_VECTOR;
    rtExcPc = {AW{1'b0}};
    btbUpd = 1'b0;
    btbUpdPc = {AW{1'b0}};
    btbUpdTaken = 1'b0;
    btbUpdTgt = {AW{1'b0}};
    for (k = 0; k < `RET_MAX; k = k + 1) begin
      ri = ahead(head_r, k);
      actNext = robTaken_r[ri] ? robTgt_r[ri] : incPc(uPc(robUop_r[ri]));
      if (rtGo && robV_r[ri] && robDone_r[ri]) begin
        if (robExc_r[ri]) begin
          rtGo = 1'b0;
          rtFlush = 1'b1;
          rtExc = 1'b1;
          rtExcPc = uPc(robUop_r[ri]);
        end else if (robUop_r[ri][1:0] == `CLS_BR) begin
          if (btbUpd) begin
            rtGo = 1'b0;
          end else begin
            btbUpd = 1'b1;
            btbUpdPc = uPc(robUop_r[ri]);
            btbUpdTaken = robTaken_r[ri];
            btbUpdTgt = robTgt_r[ri];
            rtN = rtN + 2'h1;
            if (actNext != uNext(robUop_r[ri])) begin
              rtGo = 1'b0;
              rtFlush = 1'b1;
              rtRedirect = actNext;
            end
          end
        end else begin
          rtN = rtN + 2'h1;
        end
      end else begin
        rtGo = 1'b0;
      end
    end
  end

  // Front-end delivery to the reorder buffer
  reg [1:0] feN;
  reg [UW-1:0] feU0, feU1;
  always @* begin
    feN = 2'h0;
    feU0 = decUop;
    feU1 = decUop;
    // Stall front end when fewer than two buffer slots are free, or on a flush
    if (room && !rtFlush) begin
      if (feState_r == FE_DEC) begin
        feN = 2'h1;
      end else if (feState_r == FE_TC) begin
        feU0 = tcUop_r[{tcLine_r, tcPos_r[1:0]}];
        feU1 = tcUop_r[{tcLine_r, tcPos_r[1:0] + 2'h1}];
        feN = (tcCnt_r[tcLine_r] - tcPos_r >= 3'h2) ? 2'h2 : 2'h1;
      end
    end
  end

  // Out-of-order dispatch selection
  reg [`DISP_MAX-1:0] dsV;
  reg [`DISP_MAX*TAG_W-1:0] dsT;
  reg [`DISP_MAX*2-1:0] dsC;
  reg [ROB_N-1:0] dsSel;
  reg [2:0] nTot, nAlu;
  reg nFp, nBr, ok;
  reg [TAG_W-1:0] di;
  reg [1:0] dc;
  integer j, m, p;
  always @* begin
    dsV = {`DISP_MAX{1'b0}};
    dsT = {(`DISP_MAX*TAG_W){1'b0}};
    dsC = {(`DISP_MAX*2){1'b0}};
    dsSel = {ROB_N{1'b0}};
    nTot = 3'h0;
    nAlu = 3'h0;
    nFp = 1'b0;
    nBr = 1'b0;
    for (j = 0; j < ROB_N; j = j + 1) begin
      di = ahead(head_r, j);
      dc = robUop_r[di][1:0];
      ok = robV_r[di] && !robIss_r[di] &&
        (!waitA_r[di] || robDone_r[tagA_r[di]]) &&
        (!waitB_r[di] || robDone_r[tagB_r[di]]);
      ok = ok && nTot < `DISP_MAX;
      if (dc == `CLS_ALU)
        ok = ok && nAlu < `ALU_UNITS * `ALU_PER_UNIT;
      else if (dc == `CLS_FP)
        ok = ok && !nFp && fpWait_r == 2'h0;
      else
        ok = ok && !nBr;
      if (ok) begin
        dsSel[di] = 1'b1;
        dsV[nTot] = 1'b1;
        dsT[nTot*TAG_W +: TAG_W] = di;
        dsC[nTot*2 +: 2] = dc;
        nTot = nTot + 3'h1;
        if (dc == `CLS_ALU)
          nAlu = nAlu + 3'h1;
        else if (dc == `CLS_FP)
          nFp = 1'b1;
        else
          nBr = 1'b1;
      end
    end
  end

  // Allocation of one reorder buffer slot
  task allocUop(input [TAG_W-1:0] s, input [UW-1:0] u,
    input fwdA, input fwdB);
    integer i;
    begin
      for (i = 0; i < ROB_N; i = i + 1) begin
        if (robV_r[i] && tagA_r[i] == s)
          waitA_r[i] <= 1'b0;
        if (robV_r[i] && tagB_r[i] == s)
          waitB_r[i] <= 1'b0;
      end
      robUop_r[s] <= u;
      robV_r[s] <= 1'b1;
      robDone_r[s] <= 1'b0;
      robIss_r[s] <= 1'b0;
      robExc_r[s] <= 1'b0;
      robTaken_r[s] <= 1'b0;
      waitA_r[s] <= fwdA | lastV_r[u[7:5]];
      tagA_r[s] <= fwdA ? tail_r : lastW_r[u[7:5]];
      waitB_r[s] <= fwdB | lastV_r[u[10:8]];
      tagB_r[s] <= fwdB ? tail_r : lastW_r[u[10:8]];
      lastV_r[u[4:2]] <= 1'b1;
      lastW_r[u[4:2]] <= s;
    end
  endtask

  // Reorder buffer, dispatch and commit registers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      robV_r <= {ROB_N{1'b0}};
      robDone_r <= {ROB_N{1'b0}};
      robIss_r <= {ROB_N{1'b0}};
      robExc_r <= {ROB_N{1'b0}};
      robTaken_r <= {ROB_N{1'b0}};
      waitA_r <= {ROB_N{1'b0}};
      waitB_r <= {ROB_N{1'b0}};
      head_r <= {TAG_W{1'b0}};
      tail_r <= {TAG_W{1'b0}};
      count_r <= {(TAG_W+1){1'b0}};
      lastV_r <= 8'h00;
      fpWait_r <= 2'h0;
      dspValid_r <= {`DISP_MAX{1'b0}};
      dspTag_r <= {(`DISP_MAX*TAG_W){1'b0}};
      dspCls_r <= {(`DISP_MAX*2){1'b0}};
      retValid_r <= {`RET_MAX{1'b0}};
      retDst_r <= {(`RET_MAX*3){1'b0}};
      retPc_r <= {(`RET_MAX*AW){1'b0}};
      excValid_r <= 1'b0;
      excPc_r <= {AW{1'b0}};
      flush_r <= 1'b0;
    end else begin
      dspValid_r <= rtFlush ? {`DISP_MAX{1'b0}} : dsV;
      dspTag_r <= dsT;
      dspCls_r <= dsC;
      if (nFp)
        fpWait_r <= `FP_GAP - 2'h1;
      else if (fpWait_r != 2'h0)
        fpWait_r <= fpWait_r - 2'h1;
      robIss_r <= robIss_r | dsSel;
      for (m = 0; m < ROB_N; m = m + 1)
        if (dsSel[m] && robUop_r[m][1:0] == `CLS_ALU)
          robDone_r[m] <= 1'b1;
      if (cplValid) begin
        robDone_r[cplTag] <= 1'b1;
        robExc_r[cplTag] <= cplExc;
        robTaken_r[cplTag] <= cplTaken;
        robTgt_r[cplTag] <= cplTarget;
      end
      for (m = 0; m < `RET_MAX; m = m + 1) begin
        retValid_r[m] <= m < rtN;
        retDst_r[m*3 +: 3] <= robUop_r[ahead(head_r, m)][4:2];
        retPc_r[m*AW +: AW] <= uPc(robUop_r[ahead(head_r, m)]);
        if (m < rtN) begin
          robV_r[ahead(head_r, m)] <= 1'b0;
          if (lastW_r[robUop_r[ahead(head_r, m)][4:2]] == ahead(head_r, m))
            lastV_r[robUop_r[ahead(head_r, m)][4:2]] <= 1'b0;
        end
      end
      head_r <= ahead(head_r, rtN);
      if (feN != 2'h0)
        allocUop(tail_r, feU0, 1'b0, 1'b0);
      if (feN == 2'h2)
        allocUop(ahead(tail_r, 1), feU1, feU0[4:2] == feU1[7:5],
          feU0[4:2] == feU1[10:8]);
      tail_r <= ahead(tail_r, feN);
      count_r <= count_r - {{(TAG_W-1){1'b0}}, rtN} +
        {{(TAG_W-1){1'b0}}, feN};
      excValid_r <= rtExc;
      excPc_r <= rtExcPc;
      flush_r <= rtFlush;
      if (rtFlush) begin
        robV_r <= {ROB_N{1'b0}};
        lastV_r <= 8'h00;
        head_r <= {TAG_W{1'b0}};
        tail_r <= {TAG_W{1'b0}};
        count_r <= {(TAG_W+1){1'b0}};
      end
    end
  end

  // Store the build buffer as a trace line
  task closeTrace(input [AW-1:0] nxt);
    integer q;
    begin
      tcVal_r[bldStart_r[TC_IDX_W-1:0]] <= 1'b1;
      tcTag_r[bldStart_r[TC_IDX_W-1:0]] <= bldStart_r;
      tcNext_r[bldStart_r[TC_IDX_W-1:0]] <= nxt;
      tcCnt_r[bldStart_r[TC_IDX_W-1:0]] <= bldCnt_r;
      tcHasBr_r[bldStart_r[TC_IDX_W-1:0]] <= bldHasBr_r;
      tcBrPc_r[bldStart_r[TC_IDX_W-1:0]] <= bldBrPc_r;
      for (q = 0; q < `TRACE_LEN; q = q + 1)
        tcUop_r[{bldStart_r[TC_IDX_W-1:0], q[1:0]}] <= bld_r[q];
    end
  endtask

  // Fetch, decode, trace build and trace delivery
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      feState_r <= FE_LOOK;
      pc_r <= START_PC;
      fetchReq_r <= 1'b0;
      fetchAddr_r <= {AW{1'b0}};
      ins_r <= {`INS_WIDTH{1'b0}};
      insPc_r <= {AW{1'b0}};
      ucLeft_r <= 5'h00;
      tcVal_r <= {TC_N{1'b0}};
      tcHasBr_r <= {TC_N{1'b0}};
      tcLine_r <= {TC_IDX_W{1'b0}};
      tcPos_r <= 3'h0;
      bldCnt_r <= 3'h0;
      bldStart_r <= {AW{1'b0}};
      bldBrPc_r <= {AW{1'b0}};
      bldHasBr_r <= 1'b0;
    end else begin
      if (rtFlush) begin
        feState_r <= FE_LOOK;
        pc_r <= rtRedirect;
        fetchReq_r <= 1'b0;
        ucLeft_r <= 5'h00;
        bldCnt_r <= 3'h0;
        bldHasBr_r <= 1'b0;
      end else begin
        case (feState_r)
          FE_LOOK: begin
            if (tcHit) begin
              tcLine_r <= pcIdx;
              tcPos_r <= 3'h0;
              bldCnt_r <= 3'h0;
              bldHasBr_r <= 1'b0;
              feState_r <= FE_TC;
            end else begin
              fetchReq_r <= 1'b1;
              fetchAddr_r <= pc_r;
              feState_r <= FE_WAIT;
            end
          end
          FE_WAIT: begin
            if (memValid && fetchReq_r && memAddr == fetchAddr_r) begin
              fetchReq_r <= 1'b0;
              ins_r <= memInstr;
              insPc_r <= fetchAddr_r;
              ucLeft_r <= (memInstr[`INS_CLS] == `CLS_CPLX) ?
                memInstr[`INS_IMM] : 5'h00;
              feState_r <= FE_DEC;
            end
          end
          FE_DEC: begin
            if (feN != 2'h0 && ucLeft_r != 5'h00) begin
              ucLeft_r <= ucLeft_r - 5'h01;
            end else if (feN != 2'h0) begin
              pc_r <= insNext;
              feState_r <= FE_LOOK;
              if (bldClose)
                closeTrace(insPc_r);
              if (insCx) begin
                bldCnt_r <= 3'h0;
                bldHasBr_r <= 1'b0;
              end else if (bldClose || bldCnt_r == 3'h0) begin
                bld_r[0] <= decUop;
                bldCnt_r <= 3'h1;
                bldStart_r <= insPc_r;
                bldHasBr_r <= insBr;
                bldBrPc_r <= insPc_r;
              end else begin
                bld_r[bldCnt_r[1:0]] <= decUop;
                bldCnt_r <= bldCnt_r + 3'h1;
                if (insBr) begin
                  bldHasBr_r <= 1'b1;
                  bldBrPc_r <= insPc_r;
                end
              end
            end
          end
          FE_TC: begin
            if (feN != 2'h0) begin
              tcPos_r <= tcPos_r + {1'b0, feN};
              if (tcPos_r + {1'b0, feN} >= tcCnt_r[tcLine_r]) begin
                pc_r <= tcNext_r[tcLine_r];
                feState_r <= FE_LOOK;
              end
            end
          end
          default: feState_r <= FE_LOOK;
        endcase
      end
      // Purge traces with a flipped branch
      if (btbFlip)
        for (p = 0; p < TC_N; p = p + 1)
          if (tcHasBr_r[p] && tcBrPc_r[p] == btbUpdPc)
            tcVal_r[p] <= 1'b0;
    end
  end
endmodule // uop_pipeline_trace_retire

// ---- verification/uop_far_side_model.sv ----
// Far-side memory and slow units
`timescale 1ns/1ns
`include "uop_pipeline_defines.vh"
module uop_far_side_model #(
  parameter TAG_W = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Fetch side
  input wire fetchReq_r,
  input wire [15:0] fetchAddr_r,
  output logic memValid,
  output logic [15:0] memAddr,
  output logic [15:0] memInstr,
  // Execution side
  input wire [5:0] dspValid_r,
  input wire [6*TAG_W-1:0] dspTag_r,
  input wire [11:0] dspCls_r,
  input wire flush_r,
  output logic cplValid,
  output logic [TAG_W-1:0] cplTag,
  output logic cplExc,
  output logic cplTaken,
  output logic [15:0] cplTarget,
  // Controls
  input wire [3:0] memDelay,
  input wire [3:0] cplDelay,
  input wire faultFp,
  input wire [15:0] takeTarget
);
  logic [15:0] prog [0:511] = '{default: 16'h0000};
  logic [3:0] memCnt, cplCnt;
  logic [TAG_W-1:0] tagQ[$];
  logic brQ[$];
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      memValid <= 1'b0;
      {memAddr, memInstr} <= '0;
      memCnt <= 4'h0;
    end else begin
      memValid <= 1'b0;
      // Released lines invert
      {memAddr, memInstr} <= ~{memAddr, memInstr};
      if (fetchReq_r && !memValid) begin
        memCnt <= memCnt + 4'h1;
        if (memCnt == memDelay) begin
          memValid <= 1'b1;
          memAddr <= fetchAddr_r;
          memInstr <= prog[fetchAddr_r[8:0]];
          memCnt <= 4'h0;
        end
      end else memCnt <= 4'h0;
    end
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cplValid <= 1'b0;
      {cplTag, cplExc, cplTaken, cplTarget} <= '0;
      cplCnt <= 4'h0;
      tagQ.delete();
      brQ.delete();
    end else begin
      cplValid <= 1'b0;
      {cplTag, cplExc, cplTaken, cplTarget} <= ~{cplTag, cplExc, cplTaken, cplTarget};
      if (flush_r) begin
        tagQ.delete();
        brQ.delete();
        cplCnt <= 4'h0;
      end else begin
        if (tagQ.size() != 0) begin
          cplCnt <= cplCnt + 4'h1;
          if (cplCnt == cplDelay) begin
            cplValid <= 1'b1;
            cplTag <= tagQ.pop_front();
            cplExc <= faultFp && !brQ[0];
            cplTaken <= brQ[0];
            cplTarget <= takeTarget;
            void'(brQ.pop_front());
            cplCnt <= 4'h0;
          end
        end
        for (int i = 0; i < 6; i++) begin
          if (dspValid_r[i] && dspCls_r[2*i +: 2] != `CLS_ALU) begin
            tagQ.push_back(dspTag_r[i*TAG_W +: TAG_W]);
            brQ.push_back(dspCls_r[2*i +: 2] == `CLS_BR);
          end
        end
      end
    end
  end
endmodule // uop_far_side_model

// ---- verification/uop_pipeline_checker_sva.sv ----
// Port assertions for the pipeline block
`timescale 1ns/1ns
`include "uop_pipeline_defines.vh"
module uop_pipeline_checker #(
  parameter AW = 16,
  parameter [15:0] EXC_VECTOR = 16'h0100
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Fetch
  input wire fetchReq_r,
  input wire [AW-1:0] fetchAddr_r,
  input wire memValid,
  input wire [AW-1:0] memAddr,
  // Dispatch and retire
  input wire [5:0] dspValid_r,
  input wire [11:0] dspCls_r,
  input wire [2:0] retValid_r,
  input wire excValid_r,
  input wire flush_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  function automatic int nCls(input logic [5:0] v, input logic [11:0] c,
    input logic [1:0] k);
    int n;
    n = 0;
    for (int i = 0; i < 6; i++) if (v[i] && c[2*i +: 2] == k) n++;
    return n;
  endfunction
  sequence fetchTake;
    fetchReq_r && memValid && memAddr == fetchAddr_r;
  endsequence
  sequence fetchWait;
    fetchReq_r && !(memValid && memAddr == fetchAddr_r);
  endsequence
  sequence excEvent;
    excValid_r && flush_r;
  endsequence
  chk_fetch_drop: assert property (fetchTake |=> !fetchReq_r)
    else $error("fetch held");
  chk_fetch_hold: assert property (fetchWait |=>
    flush_r || (fetchReq_r && $stable(fetchAddr_r)))
    else $error("fetch changed");
  chk_disp_packed: assert property (
    ((dspValid_r + 6'h01) & dspValid_r) == 6'h00)
    else $error("dispatch gap");
  chk_unit_caps: assert property (nCls(dspValid_r, dspCls_r, `CLS_ALU) <= 4 &&
    nCls(dspValid_r, dspCls_r, `CLS_BR) <= 1)
    else $error("unit caps");
  chk_fp_gap: assert property (nCls(dspValid_r, dspCls_r, `CLS_FP) != 0 |=>
    nCls(dspValid_r, dspCls_r, `CLS_FP) == 0)
    else $error("fp gap");
  chk_cplx_expanded: assert property (
    nCls(dspValid_r, dspCls_r, `CLS_CPLX) == 0)
    else $error("complex dispatched");
  chk_ret_packed: assert property (
    ((retValid_r + 3'h1) & retValid_r) == 3'h0)
    else $error("retire gap");
  chk_exc_flush: assert property (excValid_r |-> flush_r)
    else $error("exc no flush");
  chk_exc_vector: assert property (excEvent |->
    ##[1:3] (fetchReq_r && fetchAddr_r == EXC_VECTOR))
    else $error("no vector fetch");
  chk_flush_quiet: assert property (flush_r |-> dspValid_r == 6'h00
    ##1 (retValid_r == 3'h0 && dspValid_r == 6'h00))
    else $error("busy after flush");
endmodule // uop_pipeline_checker

bind uop_pipeline_trace_retire uop_pipeline_checker #(
  .AW(AW), .EXC_VECTOR(EXC_VECTOR)
) i_uop_pipeline_checker (
  .ref_clk(ref_clk), .resetn(resetn), .fetchReq_r(fetchReq_r),
  .fetchAddr_r(fetchAddr_r), .memValid(memValid), .memAddr(memAddr),
  .dspValid_r(dspValid_r), .dspCls_r(dspCls_r), .retValid_r(retValid_r),
  .excValid_r(excValid_r), .flush_r(flush_r)
);

// ---- verification/uop_pipeline_trace_retire_tb.sv ----
// Bench for the micro-op pipeline block
`timescale 1ns/1ns
module uop_pipeline_trace_retire_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] memDelay = 4'h1;
  logic faultFp = 1'b0;
  logic [15:0] takeTarget = 16'h0020;
  wire fetchReq_r, memValid, cplValid, cplExc, cplTaken, excValid_r, flush_r;
  wire [15:0] fetchAddr_r, memAddr, memInstr, cplTarget, excPc_r;
  wire [5:0] dspValid_r;
  wire [23:0] dspTag_r;
  wire [11:0] dspCls_r;
  wire [3:0] cplTag;
  wire [2:0] retValid_r;
  wire [8:0] retDst_r;
  wire [47:0] retPc_r;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0, aluN = 0, aluCyc = 0, cplCyc = 0;
  logic [15:0] retQ[$], excQ[$], takeQ[$];
  logic [2:0] dstQ[$];
  int flushTake[$];

  always #5 ref_clk = ~ref_clk;

  uop_pipeline_trace_retire i_uop_pipeline_trace_retire (
    .ref_clk(ref_clk), .resetn(resetn),
    .fetchReq_r(fetchReq_r), .fetchAddr_r(fetchAddr_r),
    .memValid(memValid), .memAddr(memAddr), .memInstr(memInstr),
    .dspValid_r(dspValid_r), .dspTag_r(dspTag_r), .dspCls_r(dspCls_r),
    .cplValid(cplValid), .cplTag(cplTag), .cplExc(cplExc),
    .cplTaken(cplTaken), .cplTarget(cplTarget),
    .retValid_r(retValid_r), .retDst_r(retDst_r), .retPc_r(retPc_r),
    .excValid_r(excValid_r), .excPc_r(excPc_r), .flush_r(flush_r)
  );
  uop_far_side_model i_uop_far_side_model (
    .ref_clk(ref_clk), .resetn(resetn),
    .fetchReq_r(fetchReq_r), .fetchAddr_r(fetchAddr_r),
    .memValid(memValid), .memAddr(memAddr), .memInstr(memInstr),
    .dspValid_r(dspValid_r), .dspTag_r(dspTag_r), .dspCls_r(dspCls_r),
    .flush_r(flush_r), .cplValid(cplValid), .cplTag(cplTag),
    .cplExc(cplExc), .cplTaken(cplTaken), .cplTarget(cplTarget),
    .memDelay(memDelay), .cplDelay(4'h8), .faultFp(faultFp),
    .takeTarget(takeTarget)
  );

  // Event recorders
  always @(posedge ref_clk) begin
    if (resetn) begin
      cyc++;
      for (int i = 0; i < 3; i++) begin
        if (retValid_r[i]) begin
          retQ.push_back(retPc_r[i*16 +: 16]);
          dstQ.push_back(retDst_r[i*3 +: 3]);
        end
      end
      for (int i = 0; i < 6; i++) begin
        if (dspValid_r[i] && dspCls_r[2*i +: 2] === 2'h0) begin
          aluN++;
          if (aluN == 5) aluCyc = cyc;
        end
      end
      if (cplValid && cplCyc == 0) cplCyc = cyc;
      if (excValid_r) excQ.push_back(excPc_r);
      if (fetchReq_r && memValid && memAddr === fetchAddr_r)
        takeQ.push_back(fetchAddr_r);
      if (flush_r) flushTake.push_back(takeQ.size());
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic judge(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_ret(input int n);
    for (int k = 0; retQ.size() < n && k < 600; k++) @(posedge ref_clk);
    if (retQ.size() < n) begin
      judge(1'b0, "wait timeout");
      report_and_stop();
    end
  endtask

  task automatic t_reset();
    repeat (10) @(posedge ref_clk);
    judge(fetchReq_r === 1'b0 && dspValid_r === 6'h00 &&
          retValid_r === 3'h0 && flush_r === 1'b0, "reset outs");
    resetn <= 1'b1;
    for (int k = 0; fetchReq_r !== 1'b1 && k < 20; k++) @(posedge ref_clk);
    judge(fetchReq_r === 1'b1 && fetchAddr_r === 16'h0000,
          "first fetch");
    if (fetchReq_r !== 1'b1) report_and_stop();
    $display("test reset done");
  endtask

  task automatic t_in_order();
    wait_ret(7);
    for (int i = 0; i < 7; i++) begin
      judge(retQ[i] === 16'(i) && dstQ[i] === 3'(i < 6 ? i + 1 : 0),
            "commit order");
    end
    judge(aluCyc != 0 && aluCyc < cplCyc, "no bypass");
    wait_ret(8);
    judge(retQ[7] === 16'h0020, "wrong path");
    judge(takeQ[flushTake[0]] === 16'h0020, "refetch target");
    $display("test in_order done");
  endtask

  task automatic t_complex_exc();
    takeTarget <= 16'h0100;
    faultFp <= 1'b1;
    memDelay <= 4'h0;
    wait_ret(11);
    judge(retQ[8] === 16'h0020 && retQ[9] === 16'h0020,
          "expansion");
    judge(retQ[10] === 16'h0100, "fault commit");
    judge(excQ.size() == 1 && excQ[0] === 16'h0021, "exception pc");
    judge(takeQ[flushTake[1]] === 16'h0100, "restart");
    faultFp <= 1'b0;
    $display("test complex_exc done");
  endtask

  task automatic t_trace_loop();
    int s, t, f;
    wait_ret(retQ.size() + 60);
    s = retQ.size();
    t = takeQ.size();
    f = flushTake.size();
    wait_ret(s + 40);
    judge(takeQ.size() == t, "fetch on hit");
    judge(flushTake.size() == f, "learnt flush");
    for (int i = s; i < s + 40; i++) begin
      judge(retQ[i] === ((retQ[i-1] === 16'h0103) ? 16'h0100 :
            retQ[i-1] + 16'h0001), "trace order");
    end
    $display("test trace_loop done");
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      i_uop_far_side_model.prog[i] = {11'h000, 3'(i + 1), 2'h0};
      i_uop_far_side_model.prog[i + 256] = {11'h000, 3'(i + 1), 2'h0};
    end
    // FP, ALU, branch; complex at 0x20 and FP at 0x21; loop branch at 0x103
    i_uop_far_side_model.prog[4] = 16'h0015;
    i_uop_far_side_model.prog[5] = 16'h0018;
    i_uop_far_side_model.prog[6] = 16'h0002;
    i_uop_far_side_model.prog[32] = 16'h101F;
    i_uop_far_side_model.prog[33] = 16'h0005;
    i_uop_far_side_model.prog[259] = 16'h0002;
    t_reset();
    t_in_order();
    t_complex_exc();
    t_trace_loop();
    report_and_stop();
  end
endmodule // uop_pipeline_trace_retire_tb
